// ==== hw/csfr_pkg.sv ====
package csfr_pkg;

  // Direct SFR addresses
  localparam logic [7:0] ADDR_STACK  = 8'h81;
  localparam logic [7:0] ADDR_PTR_LO = 8'h82;
  localparam logic [7:0] ADDR_PTR_HI = 8'h83;
  localparam logic [7:0] ADDR_POWER  = 8'h87;
  localparam logic [7:0] ADDR_PAGE   = 8'hC9;
  localparam logic [7:0] ADDR_STATUS = 8'hD0;
  localparam logic [7:0] ADDR_MAIN   = 8'hE0;
  localparam logic [7:0] ADDR_AUX    = 8'hF0;

  // Status word fields
  localparam int ST_CARRY    = 7;
  localparam int ST_HALF     = 6;
  localparam int ST_USER0    = 5;
  localparam int ST_BANK_HI  = 4;
  localparam int ST_BANK_LO  = 3;
  localparam int ST_WRAP     = 2;
  localparam int ST_USER1    = 1;
  localparam int ST_PARITY   = 0;

  // Power control fields
  localparam int PC_BAUD_DBL = 7;
  localparam int PC_PTR_SEL  = 4;
  localparam int PC_SPARE_B  = 3;
  localparam int PC_SPARE_A  = 2;
  localparam int PC_HALT     = 1;
  localparam int PC_SLEEP    = 0;

  // Implemented power control bits (bit 4 only with two pointers)
  localparam logic [7:0] PC_MASK_SINGLE = 8'h8F;
  localparam logic [7:0] PC_MASK_DUAL   = 8'h9F;

  // Reset values, and the byte that a blocked code read returns
  localparam logic [7:0]  RST_MAIN   = 8'h00;
  localparam logic [7:0]  RST_AUX    = 8'h00;
  localparam logic [7:0]  RST_STATUS = 8'h00;
  localparam logic [7:0]  RST_STACK  = 8'h07;
  localparam logic [15:0] RST_PTR    = 16'h0000;
  localparam logic [7:0]  RST_POWER  = 8'h00;
  localparam logic [7:0]  RST_PAGE   = 8'h00;
  localparam logic [7:0]  BLOCKED    = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } csfr_access_type;

  typedef struct packed {
    logic        main_we;
    logic [7:0]  main_wdata;
    logic        flags_we;
    logic        carry;
    logic        half;
    logic        wrap;
    logic        push;
    logic        pop;
    logic        ptr_we;
    logic [15:0] ptr_wdata;
    logic        ptr_inc;
    logic [7:0]  index;
  } csfr_datapath_type;

  typedef struct packed {
    logic        rd;
    logic [15:0] pc;
    logic [15:0] addr;
    logic [7:0]  data;
  } csfr_code_type;

  typedef struct packed {
    logic [7:0]  main_operand;
    logic [7:0]  mul_div_aux;
    logic [7:0]  status_word;
    logic [7:0]  stack_top;
    logic [15:0] pointer_set_first;
    logic [15:0] pointer_set_second;
    logic [7:0]  power_control;
    logic [7:0]  ext_page;
    logic [7:0]  rdata;
    logic [15:0] ptr_view;
    logic [7:0]  bank_base;
    logic [15:0] page_addr;
    logic [7:0]  code_data;
    logic        code_valid;
    logic [15:0] lim_s1;
    logic [15:0] lim_s2;
    logic [15:0] lim_s3;
    logic [15:0] limit;
  } csfr_state_type;

endpackage

// ==== hw/csfr_bank.sv ====
// What this block does
// - Writes to unmapped SFR addresses do nothing; reads of them return zero.
// - Status bits 4 and 3 select one of four eight-byte register banks.
// - Status bit 0 always shows odd parity of the main operand.
// - Status bits 5 and 1 are plain user flags; 7, 6, 2 hold arithmetic flags.
// - Eight-bit stack pointer incremented before each pushed byte is stored.
// - Reset loads the stack pointer with 07H.
// - Data pointer is sixteen bits, reachable whole or as two bytes.
// - With two pointers, power bit 4 routes all pointer accesses.
// - Power bits 6, 5 and unused bit 4 read as zero.
// - Power bit 7 drives the baud doubling output to the serial block.
// - Power bits 3 and 2 are spare software flags.
// - Setting power bit 0 enters idle at once and raises the idle output.
// - Idle freezes datapath updates; SFR writes still change registers.
// - An enabled interrupt in idle clears the idle bit.
// - Hardware reset ends idle like a power-on reset.
// - Setting power bit 1 enters power-down and raises its output.
// - Both bits written together give power-down, not idle.
// - Only reset leaves power-down; SFRs then take reset values.
// - Paged external address is page register high, index low.
// - Code reads from outside the protected low region into it return 00H.
module csfr_bank #(
  parameter bit DUAL_PTR   = 1'b1,
  parameter bit PROTECT_EN = 1'b1
) (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  // SFR access from the datapath
  input  wire csfr_pkg::csfr_access_type   sfr_access_in,
  output logic [7:0]                       sfr_rdata_out,
  // Dedicated datapath controls
  input  wire csfr_pkg::csfr_datapath_type datapath_in,
  input  wire logic                        wake_in,
  output logic [7:0]                       main_operand_out,
  output logic [7:0]                       status_word_out,
  output logic [7:0]                       stack_top_out,
  output logic [15:0]                      data_pointer_out,
  output logic [7:0]                       bank_base_out,
  output logic [15:0]                      page_addr_out,
  // Power indicators
  output logic                             sleep_out,
  output logic                             halt_out,
  output logic                             baud_doubler_out,
  // Code-read filter
  input  wire csfr_pkg::csfr_code_type     code_in,
  input  wire logic [15:0]                 protect_limit_in,
  output logic [7:0]                       code_data_out,
  output logic                             code_valid_out
);

  localparam logic [7:0] PC_MASK = DUAL_PTR ? csfr_pkg::PC_MASK_DUAL
                                            : csfr_pkg::PC_MASK_SINGLE;

  localparam csfr_pkg::csfr_state_type RESET_STATE = '{
    main_operand:       csfr_pkg::RST_MAIN,
    mul_div_aux:        csfr_pkg::RST_AUX,
    status_word:        csfr_pkg::RST_STATUS,
    stack_top:          csfr_pkg::RST_STACK,
    pointer_set_first:  csfr_pkg::RST_PTR,
    pointer_set_second: csfr_pkg::RST_PTR,
    power_control:      csfr_pkg::RST_POWER,
    ext_page:           csfr_pkg::RST_PAGE,
    rdata:              8'h00,
    ptr_view:           csfr_pkg::RST_PTR,
    bank_base:          8'h00,
    page_addr:          16'h0000,
    code_data:          8'h00,
    code_valid:         1'b0,
    lim_s1:             16'h0000,
    lim_s2:             16'h0000,
    lim_s3:             16'h0000,
    limit:              16'h0000
  };

  if (DUAL_PTR !== 1'b0 && DUAL_PTR !== 1'b1) begin : g_chk
    $error("DUAL_PTR must be 0 or 1");
  end

  csfr_pkg::csfr_state_type state_ff;
  csfr_pkg::csfr_state_type nxt_state;

  always_comb begin
    logic        frozen;
    logic        sel_second;
    logic [15:0] ptr;
    logic        wr;
    logic [7:0]  wd;
    logic        in_region_pc;
    logic        in_region_addr;
    nxt_state = state_ff;
    frozen = state_ff.power_control[csfr_pkg::PC_SLEEP] |
             state_ff.power_control[csfr_pkg::PC_HALT];
    sel_second = DUAL_PTR & state_ff.power_control[csfr_pkg::PC_PTR_SEL];
    ptr = sel_second ? state_ff.pointer_set_second : state_ff.pointer_set_first;
    wr = sfr_access_in.wr & ~state_ff.power_control[csfr_pkg::PC_HALT];
    wd = sfr_access_in.wdata;
    in_region_pc   = code_in.pc < state_ff.limit;
    in_region_addr = code_in.addr < state_ff.limit;

    // Limit input is static; three stages and accept once the last two agree
    nxt_state.lim_s1 = protect_limit_in;
    nxt_state.lim_s2 = state_ff.lim_s1;
    nxt_state.lim_s3 = state_ff.lim_s2;
    if (state_ff.lim_s2 == state_ff.lim_s3) begin
      nxt_state.limit = state_ff.lim_s3;
    end

    if (wake_in) begin
      nxt_state.power_control[csfr_pkg::PC_SLEEP] = 1'b0;
    end

    // Datapath updates, none while stopped
    if (!frozen) begin
      if (datapath_in.main_we) begin
        nxt_state.main_operand = datapath_in.main_wdata;
      end
      if (datapath_in.flags_we) begin
        nxt_state.status_word[csfr_pkg::ST_CARRY] = datapath_in.carry;
        nxt_state.status_word[csfr_pkg::ST_HALF]  = datapath_in.half;
        nxt_state.status_word[csfr_pkg::ST_WRAP]  = datapath_in.wrap;
      end
      if (datapath_in.push) begin
        nxt_state.stack_top = 8'(state_ff.stack_top + 8'h01);
      end else if (datapath_in.pop) begin
        nxt_state.stack_top = 8'(state_ff.stack_top - 8'h01);
      end
      if (datapath_in.ptr_we || datapath_in.ptr_inc) begin
        ptr = datapath_in.ptr_we ? datapath_in.ptr_wdata
                                 : 16'(ptr + 16'h0001);
        if (sel_second) begin
          nxt_state.pointer_set_second = ptr;
        end else begin
          nxt_state.pointer_set_first = ptr;
        end
      end
    end

    // SFR writes; unmapped addresses fall through untouched
    if (wr) begin
      unique case (sfr_access_in.addr)
        csfr_pkg::ADDR_MAIN:   nxt_state.main_operand = wd;
        csfr_pkg::ADDR_AUX:    nxt_state.mul_div_aux = wd;
        csfr_pkg::ADDR_STATUS: begin
          nxt_state.status_word[7:1] = wd[7:1];
        end
        csfr_pkg::ADDR_STACK:  nxt_state.stack_top = wd;
        csfr_pkg::ADDR_PAGE:   nxt_state.ext_page = wd;
        csfr_pkg::ADDR_PTR_LO: begin
          if (sel_second) begin
            nxt_state.pointer_set_second[7:0] = wd;
          end else begin
            nxt_state.pointer_set_first[7:0] = wd;
          end
        end
        csfr_pkg::ADDR_PTR_HI: begin
          if (sel_second) begin
            nxt_state.pointer_set_second[15:8] = wd;
          end else begin
            nxt_state.pointer_set_first[15:8] = wd;
          end
        end
        csfr_pkg::ADDR_POWER: begin
          // Set wins over a wake in the same cycle
          nxt_state.power_control = (wd & PC_MASK) |
                                    {6'h00, 2'b00};
          nxt_state.power_control[csfr_pkg::PC_SLEEP] = wd[csfr_pkg::PC_SLEEP] &
                                    ~wd[csfr_pkg::PC_HALT];
          nxt_state.power_control[csfr_pkg::PC_HALT] = wd[csfr_pkg::PC_HALT];
        end
        default: begin
        end
      endcase
    end

    // Parity tracks the operand every cycle
    nxt_state.status_word[csfr_pkg::ST_PARITY] = ^nxt_state.main_operand;

    // Registered read data
    unique case (sfr_access_in.addr)
      csfr_pkg::ADDR_MAIN:   nxt_state.rdata = state_ff.main_operand;
      csfr_pkg::ADDR_AUX:    nxt_state.rdata = state_ff.mul_div_aux;
      csfr_pkg::ADDR_STATUS: nxt_state.rdata = state_ff.status_word;
      csfr_pkg::ADDR_STACK:  nxt_state.rdata = state_ff.stack_top;
      csfr_pkg::ADDR_PAGE:   nxt_state.rdata = state_ff.ext_page;
      csfr_pkg::ADDR_PTR_LO: nxt_state.rdata = sel_second ?
                               state_ff.pointer_set_second[7:0] :
                               state_ff.pointer_set_first[7:0];
      csfr_pkg::ADDR_PTR_HI: nxt_state.rdata = sel_second ?
                               state_ff.pointer_set_second[15:8] :
                               state_ff.pointer_set_first[15:8];
      csfr_pkg::ADDR_POWER:  nxt_state.rdata = state_ff.power_control & PC_MASK;
      default:               nxt_state.rdata = 8'h00;
    endcase

    // Output copies taken from the next state so they stand in flops
    nxt_state.ptr_view = nxt_state.power_control[csfr_pkg::PC_PTR_SEL] && DUAL_PTR ?
                         nxt_state.pointer_set_second : nxt_state.pointer_set_first;
    nxt_state.bank_base = {3'b000, nxt_state.status_word[csfr_pkg::ST_BANK_HI],
                           nxt_state.status_word[csfr_pkg::ST_BANK_LO], 3'b000};
    nxt_state.page_addr = {nxt_state.ext_page, datapath_in.index};

    // Code-read filter
    nxt_state.code_valid = code_in.rd;
    if (code_in.rd) begin
      nxt_state.code_data = (PROTECT_EN && !in_region_pc && in_region_addr) ?
                            csfr_pkg::BLOCKED : code_in.data;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= RESET_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sfr_rdata_out    = state_ff.rdata;
  assign main_operand_out = state_ff.main_operand;
  assign status_word_out  = state_ff.status_word;
  assign stack_top_out    = state_ff.stack_top;
  assign data_pointer_out = state_ff.ptr_view;
  assign bank_base_out    = state_ff.bank_base;
  assign page_addr_out    = state_ff.page_addr;
  assign sleep_out        = state_ff.power_control[csfr_pkg::PC_SLEEP];
  assign halt_out         = state_ff.power_control[csfr_pkg::PC_HALT];
  assign baud_doubler_out = state_ff.power_control[csfr_pkg::PC_BAUD_DBL];
  assign code_data_out    = state_ff.code_data;
  assign code_valid_out   = state_ff.code_valid;

  // Checks
  property p_unmapped;
    @(posedge clk_in) disable iff (reset_in)
    sfr_access_in.wr && sfr_access_in.addr == 8'hA1 && !datapath_in.main_we
      |=> $stable(state_ff.main_operand) && $stable(state_ff.mul_div_aux)
          && $stable(state_ff.ext_page);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed a register");

  property p_parity;
    @(posedge clk_in) disable iff (reset_in)
    status_word_out[0] == ^main_operand_out;
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");

  property p_push;
    @(posedge clk_in) disable iff (reset_in)
    datapath_in.push && !sleep_out && !halt_out && !sfr_access_in.wr
      |=> stack_top_out == 8'($past(stack_top_out) + 8'h01);
  endproperty
  a_push: assert property (p_push) else $error("push did not increment stack");

  property p_stack_reset;
    @(posedge clk_in) $fell(reset_in) |-> stack_top_out == 8'h07 && !sleep_out && !halt_out;
  endproperty
  a_stack_reset: assert property (p_stack_reset) else $error("bad reset state");

  property p_ptr_route;
    @(posedge clk_in) disable iff (reset_in)
    DUAL_PTR && state_ff.power_control[csfr_pkg::PC_PTR_SEL] && sfr_access_in.wr && !halt_out
      && sfr_access_in.addr == csfr_pkg::ADDR_PTR_LO
      |=> $stable(state_ff.pointer_set_first)
          && state_ff.pointer_set_second[7:0] == $past(sfr_access_in.wdata);
  endproperty
  a_ptr_route: assert property (p_ptr_route) else $error("pointer write misrouted");

  property p_sleep_entry;
    @(posedge clk_in) disable iff (reset_in)
    sfr_access_in.wr && !halt_out && sfr_access_in.addr == csfr_pkg::ADDR_POWER
      && sfr_access_in.wdata[1:0] == 2'b01 |=> sleep_out && !halt_out;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("idle not entered");

  property p_halt_priority;
    @(posedge clk_in) disable iff (reset_in)
    sfr_access_in.wr && sfr_access_in.addr == csfr_pkg::ADDR_POWER
      && sfr_access_in.wdata[1:0] == 2'b11 |=> halt_out && !sleep_out;
  endproperty
  a_halt_priority: assert property (p_halt_priority) else $error("power-down lost");

  property p_wake;
    @(posedge clk_in) disable iff (reset_in)
    sleep_out && wake_in && !sfr_access_in.wr |=> !sleep_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not clear idle");

  property p_halt_sticky;
    @(posedge clk_in) disable iff (reset_in)
    halt_out |=> halt_out [*2];
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("power-down left without reset");

  property p_protect;
    @(posedge clk_in) disable iff (reset_in)
    PROTECT_EN && code_in.rd && code_in.pc >= state_ff.limit && code_in.addr < state_ff.limit
      |=> code_valid_out && code_data_out == 8'h00;
  endproperty
  a_protect: assert property (p_protect) else $error("protected byte leaked");

  property p_page;
    @(posedge clk_in) disable iff (reset_in)
    1'b1 |=> page_addr_out[7:0] == $past(datapath_in.index);
  endproperty
  a_page: assert property (p_page) else $error("paged address low byte wrong");

  property p_reserved;
    @(posedge clk_in) disable iff (reset_in)
    sfr_access_in.addr == csfr_pkg::ADDR_POWER |=> sfr_rdata_out[6:5] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved power bits read one");

  property p_bank;
    @(posedge clk_in) disable iff (reset_in)
    sfr_access_in.wr && !halt_out && sfr_access_in.addr == csfr_pkg::ADDR_STATUS
      |=> bank_base_out == {3'b000, $past(sfr_access_in.wdata[4:3]), 3'b000};
  endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");

  property p_flags;
    @(posedge clk_in) disable iff (reset_in)
    datapath_in.flags_we && !sleep_out && !halt_out && !sfr_access_in.wr
      |=> status_word_out[7] == $past(datapath_in.carry)
          && status_word_out[6] == $past(datapath_in.half)
          && status_word_out[2] == $past(datapath_in.wrap)
          && $stable(status_word_out[5]) && $stable(status_word_out[1]);
  endproperty
  a_flags: assert property (p_flags) else $error("arithmetic or user flags wrong");

  property p_frozen;
    @(posedge clk_in) disable iff (reset_in)
    (sleep_out || halt_out) && !sfr_access_in.wr
      |=> $stable(main_operand_out) && $stable(stack_top_out) && $stable(data_pointer_out);
  endproperty
  a_frozen: assert property (p_frozen) else $error("register changed while stopped");

  property p_baud;
    @(posedge clk_in) disable iff (reset_in)
    sfr_access_in.wr && !halt_out && sfr_access_in.addr == csfr_pkg::ADDR_POWER
      |=> baud_doubler_out == $past(sfr_access_in.wdata[7]);
  endproperty
  a_baud: assert property (p_baud) else $error("baud doubler not stored");

  c_sleep_wake: cover property (@(posedge clk_in) disable iff (reset_in)
    sleep_out ##1 !sleep_out);
  c_halt: cover property (@(posedge clk_in) disable iff (reset_in) $rose(halt_out));
  c_blocked: cover property (@(posedge clk_in) disable iff (reset_in)
    code_valid_out && code_data_out == 8'h00 && state_ff.limit != 16'h0000);

endmodule

// ==== verification/csfr_power_ctl.sv ====
// Outside power and clock controller: raises a clock-stop output in power-down, and
// drives a restart reset held long enough for the oscillator to settle
module csfr_power_ctl #(
  parameter int          HOLD  = 6,
  parameter logic [15:0] LIMIT = 16'h1000
) (
  // Clock
  input  wire logic        clk_in,
  // From the block
  input  wire logic        halt_in,
  // From the bench
  input  wire logic        restart_in,
  // To the block; clock stop goes to the bench only
  output logic             reset_req_out,
  output logic             clk_stop_out,
  output logic [15:0]      protect_limit_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt = 0;

  // Limit is a constant for the whole run
  assign protect_limit_out = LIMIT;

  always @(posedge clk_in) begin
    clk_stop_out <= halt_in;
  end

  always @(posedge clk_in) begin
    if (restart_in) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  assign reset_req_out = (cnt > 0);
endmodule

// ==== verification/csfr_bank_bench.sv ====
module csfr_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 6;

  logic                        clk_in = 1'b0;
  logic                        por = 1'b1;
  logic                        restart = 1'b0;
  logic                        reset_in;
  csfr_pkg::csfr_access_type   acc = '0;
  csfr_pkg::csfr_datapath_type dp = '0;
  csfr_pkg::csfr_datapath_type base = '0;
  csfr_pkg::csfr_code_type     code = '0;
  logic                        wake = 1'b0;
  logic [7:0]                  rdata, main_o, stat_o, stack_o, bank_o, cdata;
  logic [15:0]                 ptr_o, page_o, limit;
  logic                        sleep_o, halt_o, baud_o, cvalid, rreq, cstop;
  int                          err_count = 0;
  int                          n_compared = 0;

  logic [7:0]  ra [8] = '{8'hE0, 8'hF0, 8'hD0, 8'h81, 8'h82, 8'h83, 8'h87, 8'hC9};
  logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wa [7] = '{8'hE0, 8'hF0, 8'hC9, 8'hD0, 8'h87, 8'hA1, 8'h81};
  logic [7:0]  wd [7] = '{8'h55, 8'hA5, 8'h3C, 8'hFF, 8'h7C, 8'hFF, 8'h20};
  logic [7:0]  we [7] = '{8'h55, 8'hA5, 8'h3C, 8'hFE, 8'h1C, 8'h00, 8'h20};
  logic [15:0] cpc [6] = '{16'h8000, 16'h0100, 16'h8000, 16'h1000, 16'h0FFF, 16'h8000};
  logic [15:0] cad [6] = '{16'h0010, 16'h0010, 16'h2000, 16'h0FFF, 16'h0FFF, 16'h1000};
  logic [7:0]  cex [6] = '{8'h00, 8'hA5, 8'hA5, 8'h00, 8'hA5, 8'hA5};

  assign reset_in = por | rreq;

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  csfr_bank csfr_bank_inst (
    .clk_in           (clk_in),
    .reset_in         (reset_in),
    .sfr_access_in    (acc),
    .sfr_rdata_out    (rdata),
    .datapath_in      (dp),
    .wake_in          (wake),
    .main_operand_out (main_o),
    .status_word_out  (stat_o),
    .stack_top_out    (stack_o),
    .data_pointer_out (ptr_o),
    .bank_base_out    (bank_o),
    .page_addr_out    (page_o),
    .sleep_out        (sleep_o),
    .halt_out         (halt_o),
    .baud_doubler_out (baud_o),
    .code_in          (code),
    .protect_limit_in (limit),
    .code_data_out    (cdata),
    .code_valid_out   (cvalid)
  );

  csfr_power_ctl #(.HOLD(HOLD), .LIMIT(16'h1000)) csfr_power_ctl_inst (
    .clk_in            (clk_in),
    .halt_in           (halt_o),
    .restart_in        (restart),
    .reset_req_out     (rreq),
    .clk_stop_out      (cstop),
    .protect_limit_out (limit)
  );

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    acc <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk_in);
    acc.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    acc <= '{addr: a, wr: 1'b0, wdata: 8'h00};
    @(posedge clk_in);
    #1;
    d = rdata;
  endtask

  task automatic dpulse(input csfr_pkg::csfr_datapath_type v);
    @(posedge clk_in);
    dp <= v;
    @(posedge clk_in);
    dp <= base;
    #1;
  endtask

  task automatic restart_dev();
    @(posedge clk_in);
    restart <= 1'b1;
    @(posedge clk_in);
    restart <= 1'b0;
    repeat (HOLD + 6) @(posedge clk_in);
    #1;
  endtask

  task automatic finish_test();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  initial begin
    logic [7:0] r;
    csfr_pkg::csfr_datapath_type v;
    base.index = 8'h5A;
    @(posedge clk_in);
    dp <= base;
    repeat (7) @(posedge clk_in);
    por <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], r);
      chk(16'(r), 16'(rv[i]));
    end
    chk({14'h0000, sleep_o, halt_o}, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wr(wa[i], wd[i]);
      rd(wa[i], r);
      chk(16'(r), 16'(we[i]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(csfr_pkg::ADDR_STATUS, 8'(i * 8));
      chk(16'(bank_o), 16'(i * 8));
    end
    wr(csfr_pkg::ADDR_MAIN, 8'h01);
    chk(16'(stat_o[0]), 16'h0001);
    wr(csfr_pkg::ADDR_MAIN, 8'h03);
    chk(16'(stat_o[0]), 16'h0000);
    // User flags set, then arithmetic flags loaded by the datapath
    wr(csfr_pkg::ADDR_STATUS, 8'h22);
    v = base;
    v.flags_we = 1'b1;
    v.carry = 1'b1;
    v.wrap = 1'b1;
    dpulse(v);
    chk(16'(stat_o), 16'h00A6);
    v = base;
    v.push = 1'b1;
    dpulse(v);
    chk(16'(stack_o), 16'h0021);
    v.pop = 1'b1;
    dpulse(v);
    chk(16'(stack_o), 16'h0022);
    v.push = 1'b0;
    dpulse(v);
    chk(16'(stack_o), 16'h0021);
    wr(csfr_pkg::ADDR_PTR_LO, 8'h34);
    wr(csfr_pkg::ADDR_PTR_HI, 8'h12);
    chk(ptr_o, 16'h1234);
    wr(csfr_pkg::ADDR_POWER, 8'h00);
    chk(ptr_o, 16'h0000);
    v = base;
    v.ptr_we = 1'b1;
    v.ptr_wdata = 16'hABCD;
    dpulse(v);
    chk(ptr_o, 16'hABCD);
    v = base;
    v.ptr_inc = 1'b1;
    dpulse(v);
    rd(csfr_pkg::ADDR_PTR_LO, r);
    chk(16'(r), 16'h00CE);
    wr(csfr_pkg::ADDR_POWER, 8'h10);
    rd(csfr_pkg::ADDR_PTR_HI, r);
    chk({r, ptr_o[7:0]}, 16'h1234);
    chk(page_o, 16'h3C5A);
    wr(csfr_pkg::ADDR_POWER, 8'h80);
    chk(16'(baud_o), 16'h0001);
    wr(csfr_pkg::ADDR_MAIN, 8'h66);
    wr(csfr_pkg::ADDR_POWER, 8'h05);
    chk({14'h0000, sleep_o, halt_o}, 16'h0002);
    v = base;
    v.main_we = 1'b1;
    v.main_wdata = 8'h77;
    v.push = 1'b1;
    dpulse(v);
    chk({main_o, stack_o}, 16'h6621);
    @(posedge clk_in);
    wake <= 1'b1;
    @(posedge clk_in);
    wake <= 1'b0;
    #1;
    chk(16'(sleep_o), 16'h0000);
    rd(csfr_pkg::ADDR_POWER, r);
    chk(16'(r), 16'h0004);
    // Idle write and wake in one cycle: the write wins
    @(posedge clk_in);
    acc <= '{addr: csfr_pkg::ADDR_POWER, wr: 1'b1, wdata: 8'h01};
    wake <= 1'b1;
    @(posedge clk_in);
    acc.wr <= 1'b0;
    wake <= 1'b0;
    #1;
    chk(16'(sleep_o), 16'h0001);
    restart_dev();
    chk({14'h0000, sleep_o, halt_o}, 16'h0000);
    wr(csfr_pkg::ADDR_POWER, 8'h03);
    chk({14'h0000, sleep_o, halt_o}, 16'h0001);
    wr(csfr_pkg::ADDR_MAIN, 8'h99);
    chk({15'h0000, cstop}, 16'h0001);
    chk(16'(main_o), 16'h0000);
    restart_dev();
    chk({halt_o, 7'h00, stack_o}, 16'h0007);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in);
      code <= '{rd: 1'b1, pc: cpc[i], addr: cad[i], data: 8'hA5};
      @(posedge clk_in);
      #1;
      chk({7'h00, cvalid, cdata}, {8'h01, cex[i]});
    end
    @(posedge clk_in);
    code.rd <= 1'b0;
    finish_test();
  end
endmodule
